// File: common/fbgp_pkg.sv
// Purpose: Shared constants and types for the five-bit general-purpose port.
// Assumes: Byte-wide register port, one clock.
// Notes:   Offsets are register indices on the plain register port.
package fbgp_pkg;

  // ==========================================================================
  // Register map
  localparam logic [1:0] OFF_PORT  = 2'h0;
  localparam logic [1:0] OFF_LATCH = 2'h1;
  localparam logic [1:0] OFF_DIR   = 2'h2;
  localparam logic [1:0] OFF_SEGHI = 2'h3;

  // ==========================================================================
  // Field positions
  localparam int PIN_W          = 5;
  localparam int BIT_PU_J       = 5;
  localparam int BIT_PU_E       = 6;
  localparam int BIT_PU_D       = 7;
  localparam int BIT_SER1_OD    = 6;
  localparam int BIT_SER2_OD    = 7;
  localparam int BIT_CAP1_OD    = 5;
  localparam int BIT_CAP2_OD    = 6;
  localparam int BIT_SSP_OD     = 7;
  localparam int BIT_LCD_SEGMENT_26      = 2;
  localparam int PIN_RTC        = 4;

  // ==========================================================================
  // Reset values
  localparam logic [4:0] LATCH_RST  = 5'h00;
  localparam logic [4:0] DIR_RST    = 5'h1f;
  localparam logic [2:0] PU_RST     = 3'h7;
  localparam logic [1:0] SEROD_RST  = 2'h0;
  localparam logic [2:0] PERIOD_RST = 3'h0;
  localparam logic [7:0] SEGHI_RST  = 8'h00;

  // ==========================================================================
  // Bundles
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fbgp_bus_s;

  typedef struct packed {
    logic serial2Active;
    logic serial2SyncMode;
    logic serial2TxEnable;
    logic serial2TxData;
    logic serial2ClockOut;
    logic clockCalendarEnable;
    logic clockCalendarData;
    logic lcdBiasEnable;
  } fbgp_periph_s;

endpackage

// File: core/fbgp_port.sv
// Purpose: Five-pin general-purpose port with pull-up and open-drain selects.
// Assumes: Pins arrive asynchronously; peripherals are on clk.
// Notes:   Peripheral overrides never touch the stored direction bits.
//
// Summary of operation
// - Five pins, each direction and latch bit.
// - Direction 0 drives latch, 1 reads pin.
// - Pins sampled through Schmitt-trigger input path.
// - Latch bits 7,6 select serial open-drain.
// - Direction bits 7..5 select peripheral open-drain.
// - Latch bit 5 absent, reads zero.
// - Port bits 7..5 low enable pull-ups.
// - Reset disables all weak pull-ups.
// - Forced direction never alters stored bit.
// - Peripherals force output or input direction.
// - Segment 26 enable takes pin 4.
// - Clock-calendar output drives pin 4.
// - Bias duty removes pins 0,2,3 functions.
// - Serial output overrides latch on pins 1,2.
// - Software sets direction 1 for sync input.
// - Pin 2 feeds asynchronous receive input.
// - Pin 1 feeds synchronous clock input.
// - Port write loads output latches.
`timescale 1ns/1ns
`default_nettype none

module fbgp_port #(
  parameter int PINS = 5
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire fbgp_pkg::fbgp_bus_s   regBus,
  output logic [7:0]                 rdData,
  input  wire fbgp_pkg::fbgp_periph_s periph,
  input  wire logic [PINS-1:0]       pinIn,
  output logic [PINS-1:0]            pinOut,
  output logic [PINS-1:0]            pinOe,
  output logic                       lcdSegment26Enable,
  output logic                       serial2Receive,
  output logic                       serial2SyncClockIn,
  output logic                       serial2SyncDataIn,
  output logic                       pullupPortDEnable,
  output logic                       pullupPortEEnable,
  output logic                       pullupPortJEnable,
  output logic                       serial1OpenDrain,
  output logic                       serial2OpenDrain,
  output logic                       capture1OpenDrain,
  output logic                       capture2OpenDrain,
  output logic                       syncSerialOpenDrain
);

  // ==========================================================================
  // Elaboration check
  if (PINS != fbgp_pkg::PIN_W) begin : g_bad
    $error("fbgp_port supports exactly five pins");
  end

  // ==========================================================================
  // Storage
  logic [PINS-1:0] latch_r;
  logic [PINS-1:0] dir_r;
  logic [2:0]      pullupN_r;
  logic [1:0]      serOd_r;
  logic [2:0]      perOd_r;
  logic [7:0]      segHi_r;
  logic [PINS-1:0] pinMeta_r;
  logic [PINS-1:0] pinSync_r;
  logic [7:0]      rdData_nxt;

  wire logic wrPort  = regBus.wr && regBus.addr == fbgp_pkg::OFF_PORT;
  wire logic wrLatch = regBus.wr && regBus.addr == fbgp_pkg::OFF_LATCH;
  wire logic wrDir   = regBus.wr && regBus.addr == fbgp_pkg::OFF_DIR;
  wire logic wrSeg   = regBus.wr && regBus.addr == fbgp_pkg::OFF_SEGHI;

  // Both the port and latch offsets load the output latches.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      latch_r <= fbgp_pkg::LATCH_RST;
    else if (wrPort || wrLatch)
      latch_r <= regBus.wdata[PINS-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dir_r <= fbgp_pkg::DIR_RST;
    else if (wrDir)
      dir_r <= regBus.wdata[PINS-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pullupN_r <= fbgp_pkg::PU_RST;
    else if (wrPort)
      pullupN_r <= regBus.wdata[fbgp_pkg::BIT_PU_D:fbgp_pkg::BIT_PU_J];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      serOd_r <= fbgp_pkg::SEROD_RST;
    else if (wrLatch)
      serOd_r <= regBus.wdata[fbgp_pkg::BIT_SER2_OD:fbgp_pkg::BIT_SER1_OD];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      perOd_r <= fbgp_pkg::PERIOD_RST;
    else if (wrDir)
      perOd_r <= regBus.wdata[fbgp_pkg::BIT_SSP_OD:fbgp_pkg::BIT_CAP1_OD];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      segHi_r <= fbgp_pkg::SEGHI_RST;
    else if (wrSeg)
      segHi_r <= regBus.wdata;
  end

  // ==========================================================================
  // Pin input path
  // The hysteresis sits in the pad; here the level is only synchronised.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end
    else
    begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // ==========================================================================
  // Pin ownership and drive
  // Every pin resolves its owner in a fixed order: general-purpose first,
  // then the serial transceiver, the open-drain release, bias duty, the
  // clock-calendar output and last the segment driver.
  // The stored direction bits are only read here, so an override never
  // disturbs a read-modify-write of the direction register.
  logic            seg26On;
  logic            serDrive1;
  logic            serDrive2;
  logic            serData1;
  logic [PINS-1:0] serOwn;
  logic [PINS-1:0] serData;
  logic [PINS-1:0] biasOwn;
  logic [PINS-1:0] calOwn;
  logic [PINS-1:0] segOwn;
  logic [PINS-1:0] odRelease;

  assign seg26On   = segHi_r[fbgp_pkg::BIT_LCD_SEGMENT_26];
  assign serDrive1 = periph.serial2Active && !periph.lcdBiasEnable &&
                     (periph.serial2SyncMode ? periph.serial2TxEnable : 1'b1);
  assign serDrive2 = periph.serial2Active && periph.serial2SyncMode && periph.serial2TxEnable &&
                     !periph.lcdBiasEnable;
  assign serData1  = periph.serial2SyncMode ? periph.serial2ClockOut : periph.serial2TxData;

  // Only pins 1 and 2 carry transceiver outputs.
  always_comb
  begin
    serOwn     = '0;
    serData    = '0;
    serOwn[1]  = serDrive1;
    serData[1] = serData1;
    serOwn[2]  = serDrive2;
    serData[2] = periph.serial2TxData;
  end

  // Bias duty takes pins 0, 2 and 3; the calendar and the segment take pin 4.
  always_comb
  begin
    biasOwn    = '0;
    calOwn     = '0;
    segOwn     = '0;
    biasOwn[0] = periph.lcdBiasEnable;
    biasOwn[2] = periph.lcdBiasEnable;
    biasOwn[3] = periph.lcdBiasEnable;
    calOwn[fbgp_pkg::PIN_RTC] = periph.clockCalendarEnable;
    segOwn[fbgp_pkg::PIN_RTC] = seg26On;
  end

  // With serial 2 active and its open-drain bit set, pin 1 (not pin 2) is released instead of driving a high level.
  always_comb
  begin
    odRelease    = '0;
    odRelease[1] = periph.serial2Active && serOd_r[1];
  end

  for (genvar p = 0; p < PINS; p++)
  begin : g_pin
    logic drvData;
    logic drvEn;

    always_comb
    begin
      drvData = latch_r[p];
      drvEn   = !dir_r[p];
      if (serOwn[p])
      begin
        drvData = serData[p];
        drvEn   = 1'b1;
      end
      if (odRelease[p] && drvData)
        drvEn = 1'b0;
      if (biasOwn[p])
        drvEn = 1'b0;
      if (calOwn[p])
      begin
        drvData = periph.clockCalendarData;
        drvEn   = 1'b1;
      end
      if (segOwn[p])
      begin
        drvData = 1'b0;
        drvEn   = 1'b0;
      end
    end

    assign pinOut[p] = drvData;
    assign pinOe[p]  = drvEn;
  end

  // ==========================================================================
  // Peripheral inputs and open-drain selects
  assign serial2Receive      = dir_r[2] && !periph.lcdBiasEnable && pinSync_r[2];
  assign serial2SyncDataIn   = dir_r[2] && !periph.lcdBiasEnable && pinSync_r[2];
  assign serial2SyncClockIn  = dir_r[1] && pinSync_r[1];
  assign lcdSegment26Enable  = seg26On;
  assign pullupPortDEnable   = !pullupN_r[2];
  assign pullupPortEEnable   = !pullupN_r[1];
  assign pullupPortJEnable   = !pullupN_r[0];
  assign serial2OpenDrain    = serOd_r[1];
  assign serial1OpenDrain    = serOd_r[0];
  assign syncSerialOpenDrain = perOd_r[2];
  assign capture2OpenDrain   = perOd_r[1];
  assign capture1OpenDrain   = perOd_r[0];

  // ==========================================================================
  // Read path
  // Each register's read layout is assembled once so that its fields stay visible.
  logic [7:0] rdPortWord;
  logic [7:0] rdLatchWord;
  logic [7:0] rdDirWord;
  logic [7:0] rdSegWord;

  assign rdPortWord  = {pullupN_r, pinSync_r};
  assign rdLatchWord = {serOd_r, 1'b0, latch_r};
  assign rdDirWord   = {perOd_r, dir_r};
  assign rdSegWord   = segHi_r;

  always_comb
  begin
    rdData_nxt = 8'h00;
    case (regBus.addr)
      fbgp_pkg::OFF_PORT:  rdData_nxt = rdPortWord;
      fbgp_pkg::OFF_LATCH: rdData_nxt = rdLatchWord;
      fbgp_pkg::OFF_DIR:   rdData_nxt = rdDirWord;
      fbgp_pkg::OFF_SEGHI: rdData_nxt = rdSegWord;
      default:             rdData_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdData <= 8'h00;
    else if (regBus.rd)
      rdData <= rdData_nxt;
    else
      rdData <= 8'h00;
  end

endmodule

`default_nettype wire

// File: sim/fbgp_pad_model.sv
// Purpose: Board pad model for the five-pin port.
// Assumes: Undriven pads follow the board level.
// Notes:   None.
`timescale 1ns/1ns
`default_nettype none
module fbgp_pad_model (
  input  wire logic [4:0] pinOut,
  input  wire logic [4:0] pinOe,
  input  wire logic [4:0] extLevel,
  output logic [4:0]      pinIn
);
  // ======================================
  // Pads
  // A released pad must not echo the last driven value.
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule
`default_nettype wire

// File: sim/fbgp_port_asserts.sv
// Purpose: Port checker.
// Assumes: One clock.
// Notes:   None.
`timescale 1ns/1ns
`default_nettype none
module fbgp_port_asserts #(
  parameter int PINS = 5
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire fbgp_pkg::fbgp_bus_s    regBus,
  input wire logic [7:0]             rdData,
  input wire fbgp_pkg::fbgp_periph_s periph,
  input wire logic [PINS-1:0]        pinOut,
  input wire logic [PINS-1:0]        pinOe,
  input wire logic                   lcdSegment26Enable,
  input wire logic                   pullupPortDEnable,
  input wire logic                   pullupPortEEnable,
  input wire logic                   pullupPortJEnable,
  input wire logic                   serial1OpenDrain,
  input wire logic                   serial2OpenDrain,
  input wire logic                   capture1OpenDrain,
  input wire logic                   capture2OpenDrain,
  input wire logic                   syncSerialOpenDrain
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ======================================
  // Checks
  a_pullup_write: assert property (regBus.wr && regBus.addr == 2'h0 |=>
    {pullupPortDEnable, pullupPortEEnable, pullupPortJEnable} == ~$past(regBus.wdata[7:5])) else $error("pull-up bad");
  a_latch_hole: assert property (regBus.rd && regBus.addr == 2'h1 |=> !rdData[5]) else $error("latch bit 5 set");
  a_ser_od: assert property (regBus.wr && regBus.addr == 2'h1 |=>
    {serial2OpenDrain, serial1OpenDrain} == $past(regBus.wdata[7:6])) else $error("serial od bad");
  a_per_od: assert property (regBus.wr && regBus.addr == 2'h2 |=>
    {syncSerialOpenDrain, capture2OpenDrain, capture1OpenDrain} == $past(regBus.wdata[7:5])) else $error("od bad");
  a_rd_quiet: assert property (!regBus.rd |=> rdData == 8'h00) else $error("read data not idle");
  a_rtc_drive: assert property (periph.clockCalendarEnable && !lcdSegment26Enable |->
    pinOe[4] && pinOut[4] == periph.clockCalendarData) else $error("calendar pin bad");
  a_bias_release: assert property (periph.lcdBiasEnable |-> !pinOe[0] && !pinOe[2] && !pinOe[3]) else $error("bias");
  a_pu_reset: assert property ($rose(rst_b) |-> !pullupPortDEnable && !pullupPortEEnable && !pullupPortJEnable)
    else $error("pull-up on after reset");
endmodule
bind fbgp_port fbgp_port_asserts #(.PINS(PINS)) chk (.*);
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Port testbench.
// Assumes: Pad model closes the pin loop.
// Notes:   Reads are checked from a queue.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  fbgp_pkg::fbgp_bus_s    regBus = '0;
  fbgp_pkg::fbgp_periph_s periph = '0;
  logic [4:0]             extLevel = 5'h00;
  logic [4:0]             pinIn, pinOut, pinOe;
  logic [7:0]             rdData, lat, pv;
  logic                   seg, rxd, sck, sdi, puD, puE, puJ;
  logic                   rdSeen = 1'b0;
  logic [7:0]             expQ[$];
  int                     failures = 0;
  int                     comparisons = 0;
  int                     cycles = 0;
  always #5 clk = ~clk;
  fbgp_port dut (.clk(clk), .rst_b(rst_b), .regBus(regBus), .rdData(rdData), .periph(periph), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .lcdSegment26Enable(seg), .serial2Receive(rxd), .serial2SyncClockIn(sck),
    .serial2SyncDataIn(sdi), .pullupPortDEnable(puD), .pullupPortEEnable(puE), .pullupPortJEnable(puJ),
    .serial1OpenDrain(), .serial2OpenDrain(), .capture1OpenDrain(), .capture2OpenDrain(), .syncSerialOpenDrain());
  fbgp_pad_model pads (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));
  // ======================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [1:0] a, input logic [7:0] d, input logic r);
    regBus <= {a, d, ~r, r};
    if (r)
      expQ.push_back(d);
    @(posedge clk);
    regBus <= '0;
    @(posedge clk);
  endtask
  task final_report;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ======================================
  // Watchers
  always @(posedge clk)
  begin
    if (rdSeen)
      chk(rdData, expQ.pop_front());
    rdSeen = regBus.rd;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      final_report();
    end
  end
  // ======================================
  // Tests
  initial
  begin
    void'($urandom(75202));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    acc(2'h1, 8'h00, 1'b1);
    acc(2'h2, 8'h1f, 1'b1);
    acc(2'h3, 8'h00, 1'b1);
    acc(2'h0, 8'he0, 1'b1);
    $display("reset test done");
    acc(2'h2, 8'h00, 1'b0);
    repeat (4)
    begin
      lat = 8'($urandom);
      acc(2'h1, lat, 1'b0);
      acc(2'h1, {lat[7:6], 1'b0, lat[4:0]}, 1'b1);
      chk({pinOe, pinOut[2:0]}, {5'h1f, lat[2:0]});
      chk({3'h0, pinOut}, {3'h0, lat[4:0]});
    end
    pv = 8'($urandom);
    acc(2'h0, pv, 1'b0);
    acc(2'h1, {lat[7:6], 1'b0, pv[4:0]}, 1'b1);
    acc(2'h0, pv, 1'b1);
    chk({5'h0, puD, puE, puJ}, {5'h0, ~pv[7:5]});
    $display("output test done");
    acc(2'h2, 8'h1f, 1'b0);
    extLevel <= 5'($urandom);
    repeat (3) @(posedge clk);
    acc(2'h0, {pv[7:5], extLevel}, 1'b1);
    chk({pinOe, rxd, sck, sdi}, {5'h0, extLevel[2], extLevel[1], extLevel[2]});
    periph <= 8'h06;
    acc(2'h2, 8'h1f, 1'b1);
    chk({3'h0, pinOe}, 8'h10);
    acc(2'h3, 8'h04, 1'b0);
    chk({7'h0, seg}, 8'h01);
    chk({3'h0, pinOe}, 8'h00);
    acc(2'h3, 8'h00, 1'b0);
    periph <= 8'ha0;
    @(posedge clk);
    #1 chk({6'h0, pinOe[1], pinOut[1]}, 8'h02);
    periph <= 8'hf0;
    @(posedge clk);
    #1 chk({4'h0, pinOe[2:1], pinOut[2:1]}, 8'h0e);
    acc(2'h2, {pv[7:5], 5'h00}, 1'b0);
    acc(2'h2, {pv[7:5], 5'h00}, 1'b1);
    periph <= 8'h01;
    @(posedge clk);
    #1 chk({3'h0, pinOe}, 8'h12);
    $display("override test done");
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
